// >>> hdl/eeprom_ctrl_pkg.sv
/*
 Constants, timing and state encodings shared by the two-wire memory controller files.
 Assumes a 125 MHz reference clock and a bus master that drives the serial clock line.
*/
package eeprom_ctrl_pkg;
    localparam int ADDR_W = 15;
    localparam int OTP_AW = 6;
    localparam int PAGE_AW = 5;
    localparam int TMR_W = 16;
    localparam int PIN_N = 6;
    localparam int PIN_SCL = 0;
    localparam int PIN_SDA = 1;
    localparam int PIN_SEL0 = 2;
    localparam int PIN_WP = 5;
    localparam logic [3:0] CODE_ARRAY = 4'ha;
    localparam logic [3:0] CODE_OTP = 4'hb;
    localparam logic [ADDR_W-1:0] MEM_LAST = 15'h0fff;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [3:0] BIT_ARM = 4'hf;
    localparam logic [6:0] WCNT_FULL = 7'h40;
    // Arbitrary neutral fill for the factory half of the one-time area
    localparam logic [7:0] FACTORY_FILL = 8'h00;
    localparam int CLK_PERIOD_NS = 8;
    localparam int BYTE_WR_NS = 60000;
    localparam int BYTE_WR_CYC = BYTE_WR_NS / CLK_PERIOD_NS;
    typedef enum logic [2:0] {
        ST_IDLE, ST_CTRL, ST_ADDR_HI, ST_ADDR_LO, ST_WDATA, ST_RSTART, ST_RDATA, ST_IGNORE
    } bus_state_e;
endpackage

// >>> hdl/two_wire_pin_sync.sv
/*
 Two-flop synchronisers for the bus and strap pins, plus clock edge and START/STOP detection.
 Assumes the pins are asynchronous to i_ref_clk and change far slower than it.
*/
`timescale 1ns/100ps
module two_wire_pin_sync #(
    parameter int N = eeprom_ctrl_pkg::PIN_N
) (
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic [N-1:0] i_pins,
    output logic [N-1:0] o_level,
    output logic o_scl_rise,
    output logic o_scl_fall,
    output logic o_start,
    output logic o_stop
);
    import eeprom_ctrl_pkg::*;
    logic [N-1:0] s1_q;
    logic [N-1:0] s2_q;
    logic [N-1:0] s3_q;
    logic [N-1:0] s1_d;
    logic [N-1:0] s2_d;
    logic [N-1:0] s3_d;

    // One chain per pin
    for (genvar g = 0; g < N; g++)
    begin : g_sync
        always_comb
        begin
            s1_d[g] = i_pins[g];
            s2_d[g] = s1_q[g];
            s3_d[g] = s2_q[g];
        end
        always_ff @(posedge i_ref_clk or negedge i_resetn)
        begin
            if (!i_resetn)
            begin
                // Idle high level, so no false edge follows reset
                s1_q[g] <= 1'b1;
                s2_q[g] <= 1'b1;
                s3_q[g] <= 1'b1;
            end
            else
            begin
                s1_q[g] <= s1_d[g];
                s2_q[g] <= s2_d[g];
                s3_q[g] <= s3_d[g];
            end
        end
    end

    assign o_level = s2_q;
    assign o_scl_rise = s2_q[PIN_SCL] & ~s3_q[PIN_SCL];
    assign o_scl_fall = ~s2_q[PIN_SCL] & s3_q[PIN_SCL];
    // Data edges while the clock stays high
    assign o_start = s2_q[PIN_SCL] & s3_q[PIN_SCL] & ~s2_q[PIN_SDA] & s3_q[PIN_SDA];
    assign o_stop = s2_q[PIN_SCL] & s3_q[PIN_SCL] & s2_q[PIN_SDA] & ~s3_q[PIN_SDA];
endmodule

// >>> hdl/i2c_eeprom_otp_write_read_ctrl.sv
/*
 Command logic of a two-wire serial memory slave: one-time area write, write protect,
 busy polling and the three read forms over one shared address pointer.
 Assumes the main array sits outside and answers i_rd_data for o_rd_addr in the same clock.
*/
// Functional notes
// - One-time user area accepts a single executed write, then locks; the lock here is volatile, and reset clears it.
// - Control code 1011 selects one-time area writes, 1010 main array.
// - STOP after one-time write programs buffered bytes from transmitted address.
// - One-time writes use low six address bits, upper bits forced zero.
// - Beyond 64 bytes the 64-byte buffer wraps, overwriting earliest bytes.
// - Pointer wraps to first byte of one-time area during its writes.
// - No control byte acknowledge while the internal write runs.
// - First buffered byte at transmitted address, following bytes consecutive.
// - Write protect high: ack everything, no cycle, no lock, stay ready.
// - Blocked writes still load and advance pointer within the page.
// - Bytes programmed one after another, one byte time each.
// - Write protect high blocks all writes, low allows them; here main array writes only move the pointer and are never programmed.
// - Write protect sampled only at STOP of each write command.
// - Master polls with write control bytes until the device acknowledges.
// - Direction bit one requests a read; three read forms supported.
// - One pointer serves both main array and one-time area.
// - Pointer holds last address plus one, rolling over to zero.
// - Read control byte acked, byte at pointer sent, STOP ends sending.
// - Random read: address write, repeated START, read from loaded pointer.
// - Master ack fetches next byte; pointer steps per byte; nack ends.
// - Control byte: code, three select bits matching pins, direction bit.
// - Address high then low byte follow; fifteen address bits used.
// - Matching control byte and received bytes acked low on ninth clock.
`timescale 1ns/100ps
module i2c_eeprom_otp_write_read_ctrl #(
    parameter int BYTE_WR_CYC = eeprom_ctrl_pkg::BYTE_WR_CYC
) (
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_o,
    output logic o_sda_oe_n,
    input wire logic i_select_pin_bit0,
    input wire logic i_select_pin_bit1,
    input wire logic i_select_pin_bit2,
    input wire logic i_write_protect,
    output logic [eeprom_ctrl_pkg::ADDR_W-1:0] o_rd_addr,
    input wire logic [7:0] i_rd_data,
    output logic o_busy,
    output logic o_otp_locked
);
    import eeprom_ctrl_pkg::*;
    localparam logic [TMR_W-1:0] TMR_LAST = TMR_W'(BYTE_WR_CYC - 1);

    logic [PIN_N-1:0] lvl;
    logic re;
    logic fe;
    logic start;
    logic stop;
    logic sda;
    logic wp;
    logic [2:0] sel;
    bus_state_e state_q, state_d;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] shift_q, shift_d;
    logic [7:0] tx_q, tx_d;
    logic oe_n_q, oe_n_d;
    logic mack_q, mack_d;
    logic otp_q, otp_d;
    logic [7:0] addr_hi_q, addr_hi_d;
    logic [ADDR_W-1:0] ptr_q, ptr_d;
    logic [OTP_AW-1:0] start_q, start_d;
    logic [6:0] wcnt_q, wcnt_d;
    logic [OTP_AW-1:0] widx_q, widx_d;
    logic busy_q, busy_d;
    logic locked_q, locked_d;
    logic [6:0] pidx_q, pidx_d;
    logic [TMR_W-1:0] tmr_q, tmr_d;
    logic buf_we;
    logic mem_we;
    logic cycle_go;
    logic sel_ok;
    logic [15:0] addr_full;
    logic [7:0] rd_byte;
    logic [OTP_AW-1:0] mem_addr;
    logic [7:0] wbuf [0:(1<<OTP_AW)-1];
    logic [7:0] otp_mem [0:(1<<OTP_AW)-1];

    two_wire_pin_sync #(.N(PIN_N)) u_sync (
        .i_ref_clk(i_ref_clk),
        .i_resetn(i_resetn),
        .i_pins({i_write_protect, i_select_pin_bit2, i_select_pin_bit1,
                 i_select_pin_bit0, i_sda, i_scl}),
        .o_level(lvl),
        .o_scl_rise(re),
        .o_scl_fall(fe),
        .o_start(start),
        .o_stop(stop)
    );

    assign sda = lvl[PIN_SDA];
    assign wp = lvl[PIN_WP];
    assign sel = lvl[PIN_SEL0+2:PIN_SEL0];
    assign addr_full = {addr_hi_q, shift_q};

    // Page step for writes: one-time area wraps in 64, array in its 32-byte page
    function automatic logic [ADDR_W-1:0] page_inc(input logic [ADDR_W-1:0] p,
                                                  input logic otp);
        logic [OTP_AW-1:0] lo6;
        logic [PAGE_AW-1:0] lo5;
        lo6 = p[OTP_AW-1:0] + 1'b1;
        lo5 = p[PAGE_AW-1:0] + 1'b1;
        if (otp)
            page_inc = {{(ADDR_W-OTP_AW){1'b0}}, lo6};
        else
            page_inc = {p[ADDR_W-1:PAGE_AW], lo5};
    endfunction

    // Read step with roll-over after the last address
    function automatic logic [ADDR_W-1:0] seq_inc(input logic [ADDR_W-1:0] p);
        if (p == MEM_LAST)
            seq_inc = '0;
        else
            seq_inc = p + 1'b1;
    endfunction

    // Read source: both areas through the one pointer
    always_comb
    begin
        if (!otp_q)
            rd_byte = i_rd_data;
        else if (ptr_q[OTP_AW])
            rd_byte = FACTORY_FILL;
        else
            rd_byte = otp_mem[ptr_q[OTP_AW-1:0]];
    end

    assign sel_ok = (shift_q[7:4] == CODE_ARRAY || shift_q[7:4] == CODE_OTP)
                    && shift_q[3:1] == sel && !busy_q;
    assign cycle_go = stop && state_q == ST_WDATA && otp_q && wcnt_q != 7'h00
                      && !wp && !locked_q;

    // Bus engine
    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        shift_d = shift_q;
        tx_d = tx_q;
        oe_n_d = oe_n_q;
        mack_d = mack_q;
        otp_d = otp_q;
        addr_hi_d = addr_hi_q;
        ptr_d = ptr_q;
        start_d = start_q;
        wcnt_d = wcnt_q;
        widx_d = widx_q;
        buf_we = 1'b0;
        if (start)
        begin
            state_d = ST_CTRL;
            cnt_d = BIT_ARM;
            oe_n_d = 1'b1;
        end
        else if (stop)
        begin
            state_d = ST_IDLE;
            oe_n_d = 1'b1;
        end
        else
        begin
            if (re)
            begin
                if (cnt_q < BIT_ACK)
                    shift_d = {shift_q[6:0], sda};
                else if (cnt_q == BIT_ACK && state_q == ST_RDATA)
                begin
                    mack_d = !sda;
                    ptr_d = seq_inc(ptr_q);
                end
            end
            if (fe)
            begin
                if (cnt_q == BIT_ARM)
                    cnt_d = 4'h0;
                else if (state_q == ST_RDATA)
                begin
                    if (cnt_q < BIT_LAST)
                    begin
                        cnt_d = cnt_q + 4'h1;
                        tx_d = {tx_q[6:0], 1'b0};
                        oe_n_d = tx_q[6];
                    end
                    else if (cnt_q == BIT_LAST)
                    begin
                        cnt_d = BIT_ACK;
                        oe_n_d = 1'b1;
                    end
                    else if (mack_q)
                    begin
                        cnt_d = 4'h0;
                        tx_d = rd_byte;
                        oe_n_d = rd_byte[7];
                    end
                    else
                        state_d = ST_IGNORE;
                end
                else if (state_q != ST_IDLE && state_q != ST_IGNORE)
                begin
                    if (cnt_q < BIT_LAST)
                        cnt_d = cnt_q + 4'h1;
                    else if (cnt_q == BIT_LAST)
                    begin
                        cnt_d = BIT_ACK;
                        oe_n_d = 1'b0;
                        case (state_q)
                            ST_CTRL:
                            begin
                                if (sel_ok)
                                begin
                                    otp_d = shift_q[7:4] == CODE_OTP;
                                    wcnt_d = 7'h00;
                                    widx_d = '0;
                                    state_d = shift_q[0] ? ST_RSTART : ST_ADDR_HI;
                                end
                                else
                                begin
                                    oe_n_d = 1'b1;
                                    state_d = ST_IGNORE;
                                end
                            end
                            ST_ADDR_HI:
                            begin
                                addr_hi_d = shift_q;
                                state_d = ST_ADDR_LO;
                            end
                            ST_ADDR_LO:
                            begin
                                start_d = shift_q[OTP_AW-1:0];
                                if (otp_q)
                                    ptr_d = {{(ADDR_W-OTP_AW){1'b0}},
                                             shift_q[OTP_AW-1:0]};
                                else
                                    ptr_d = addr_full[ADDR_W-1:0];
                                state_d = ST_WDATA;
                            end
                            ST_WDATA:
                            begin
                                buf_we = 1'b1;
                                widx_d = widx_q + 1'b1;
                                if (wcnt_q != WCNT_FULL)
                                    wcnt_d = wcnt_q + 7'h01;
                                ptr_d = page_inc(ptr_q, otp_q);
                            end
                            default:
                                oe_n_d = 1'b1;
                        endcase
                    end
                    else
                    begin
                        cnt_d = 4'h0;
                        oe_n_d = 1'b1;
                        if (state_q == ST_RSTART)
                        begin
                            tx_d = rd_byte;
                            oe_n_d = rd_byte[7];
                            state_d = ST_RDATA;
                        end
                    end
                end
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            state_q <= ST_IDLE;
            cnt_q <= BIT_ARM;
            shift_q <= 8'h00;
            tx_q <= 8'h00;
            oe_n_q <= 1'b1;
            mack_q <= 1'b0;
            otp_q <= 1'b0;
            addr_hi_q <= 8'h00;
            ptr_q <= '0;
            start_q <= '0;
            wcnt_q <= 7'h00;
            widx_q <= '0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            shift_q <= shift_d;
            tx_q <= tx_d;
            oe_n_q <= oe_n_d;
            mack_q <= mack_d;
            otp_q <= otp_d;
            addr_hi_q <= addr_hi_d;
            ptr_q <= ptr_d;
            start_q <= start_d;
            wcnt_q <= wcnt_d;
            widx_q <= widx_d;
        end
    end

    // Internal write cycle, one byte time per buffered byte
    assign mem_addr = start_q + pidx_q[OTP_AW-1:0];

    always_comb
    begin
        busy_d = busy_q;
        locked_d = locked_q;
        pidx_d = pidx_q;
        tmr_d = tmr_q;
        mem_we = 1'b0;
        if (cycle_go)
        begin
            busy_d = 1'b1;
            locked_d = 1'b1;
            pidx_d = 7'h00;
            tmr_d = '0;
        end
        else if (busy_q)
        begin
            if (tmr_q == TMR_LAST)
            begin
                tmr_d = '0;
                mem_we = 1'b1;
                pidx_d = pidx_q + 7'h01;
                if (pidx_q + 7'h01 == wcnt_q)
                    busy_d = 1'b0;
            end
            else
                tmr_d = tmr_q + 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            busy_q <= 1'b0;
            locked_q <= 1'b0;
            pidx_q <= 7'h00;
            tmr_q <= '0;
        end
        else
        begin
            busy_q <= busy_d;
            locked_q <= locked_d;
            pidx_q <= pidx_d;
            tmr_q <= tmr_d;
        end
    end

    // Storage without reset
    always_ff @(posedge i_ref_clk)
    begin
        if (buf_we)
            wbuf[widx_q] <= shift_q;
        if (mem_we)
            otp_mem[mem_addr] <= wbuf[pidx_q[OTP_AW-1:0]];
    end

    assign o_sda_o = 1'b0;
    assign o_sda_oe_n = oe_n_q;
    assign o_rd_addr = ptr_q;
    assign o_busy = busy_q;
    assign o_otp_locked = locked_q;

    // Checks
    int busy_len;
    always_ff @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            busy_len <= 0;
        else if (cycle_go)
            busy_len <= 0;
        else if (busy_q)
            busy_len <= busy_len + 1;
    end

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);

    sequence ctrl_done;
        fe && !start && !stop && cnt_q == BIT_LAST && state_q == ST_CTRL;
    endsequence
    sequence data_done;
        fe && !start && !stop && cnt_q == BIT_LAST && state_q == ST_WDATA;
    endsequence

    nack_busy_a: assert property (ctrl_done and busy_q |=> oe_n_q && state_q == ST_IGNORE)
        else $error("control byte acked during write cycle");
    nack_mismatch_a: assert property (ctrl_done and shift_q[3:1] != sel
                                      |=> oe_n_q[*2])
        else $error("mismatching control byte acked");
    ack_data_a: assert property (data_done |=> !oe_n_q)
        else $error("data byte not acked");
    wp_skip_a: assert property (stop && state_q == ST_WDATA && wp && !busy_q
                                |=> !busy_q && $stable(locked_q))
        else $error("protected write started a cycle");
    lock_once_a: assert property ($rose(busy_q) |-> $rose(locked_q))
        else $error("write cycle ran on a locked area");
    otp_mask_a: assert property (data_done and otp_q
                                 |=> ptr_q[ADDR_W-1:OTP_AW] == '0)
        else $error("one-time write pointer left its area");
    otp_wrap_a: assert property (data_done and otp_q
                                 |=> ptr_q[OTP_AW-1:0] == $past(ptr_q[OTP_AW-1:0]) + 1'b1)
        else $error("one-time write pointer step wrong");
    prog_time_a: assert property ($fell(busy_q)
                                  |-> busy_len == int'($past(wcnt_q)) * BYTE_WR_CYC)
        else $error("write cycle length wrong");
    read_step_a: assert property (re && !start && !stop && cnt_q == BIT_ACK
                                  && state_q == ST_RDATA
                                  |=> ptr_q == seq_inc($past(ptr_q)))
        else $error("read pointer did not step");
endmodule

// >>> test/bus_master_model.sv
/*
 Two-wire bus master model: START, STOP, byte write and byte read.
 Assumes the open-drain data wire and its pull-up are resolved by the bench.
*/
`timescale 1ns/100ps
module bus_master_model (
    output logic o_scl,
    output logic o_sda,
    input wire logic i_sda
);
    initial
    begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    // Also serves as repeated START and as polling START
    task automatic start_c();
        o_sda = 1'b1;
        #40 o_scl = 1'b1;
        #40 o_sda = 1'b0;
        #40 o_scl = 1'b0;
        #40;
    endtask
    task automatic stop_c();
        o_sda = 1'b0;
        #40 o_scl = 1'b1;
        #40 o_sda = 1'b1;
        #40;
    endtask
    task automatic bit_c(input logic b, output logic s);
        o_sda = b;
        #40 o_scl = 1'b1;
        #40 s = i_sda;
        #40 o_scl = 1'b0;
        #40;
    endtask
    // Bytes go MSB first, then the ninth slot is sampled for acknowledge
    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            bit_c(b[i], s);
        end
        bit_c(1'b1, s);
        ack = ~s;
    endtask
    task automatic rd_byte(input logic ack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            bit_c(1'b1, s);
            b[i] = s;
        end
        bit_c(~ack, s);
    endtask
endmodule

// >>> test/i2c_eeprom_otp_write_read_ctrl_test.sv
/*
 Self-checking bench for the two-wire memory command logic.
 Assumes the bus master model and a main array stand-in derived from the pointer.
*/
`timescale 1ns/100ps
module i2c_eeprom_otp_write_read_ctrl_test;
    import eeprom_ctrl_pkg::*;
    localparam int WR_CYC = 20;
    localparam int LIMIT = 60000;
    localparam logic [2:0] SEL = 3'b101;
    typedef struct packed {logic [7:0] ctrl; logic ack;} row_s;
    localparam row_s ROWS [7] = '{'{{CODE_ARRAY, SEL, 1'b0}, 1'b1},
        '{{CODE_OTP, SEL, 1'b0}, 1'b1}, '{{4'hc, SEL, 1'b0}, 1'b0},
        '{{CODE_ARRAY, 3'b001, 1'b0}, 1'b0}, '{{CODE_ARRAY, SEL, 1'b1}, 1'b1},
        '{{CODE_OTP, SEL, 1'b1}, 1'b1}, '{{4'h2, SEL, 1'b1}, 1'b0}};
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic wp = 1'b0;
    logic [2:0] sel = SEL;
    logic scl, sda_m, sda_o, oe_n, busy, locked, ack;
    logic [ADDR_W-1:0] rd_addr;
    logic [7:0] rd_data, d;
    wire sda;
    int fail_count = 0;
    int comparisons = 0;
    int cyc = 0;
    int busy_cnt = 0;
    assign sda = sda_m & (oe_n | sda_o);
    assign rd_data = rd_addr[7:0] ^ 8'hc3;
    i2c_eeprom_otp_write_read_ctrl #(.BYTE_WR_CYC(WR_CYC)) i_i2c_eeprom_otp_write_read_ctrl (
        .i_ref_clk(clk), .i_resetn(resetn), .i_scl(scl), .i_sda(sda),
        .o_sda_o(sda_o), .o_sda_oe_n(oe_n), .i_select_pin_bit0(sel[0]),
        .i_select_pin_bit1(sel[1]), .i_select_pin_bit2(sel[2]), .i_write_protect(wp),
        .o_rd_addr(rd_addr), .i_rd_data(rd_data), .o_busy(busy), .o_otp_locked(locked));
    bus_master_model i_bus_master_model (.o_scl(scl), .o_sda(sda_m), .i_sda(sda));
    initial
    begin
        forever #4 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (busy === 1'b1)
            busy_cnt++;
        if (cyc == LIMIT)
        begin
            fail_count++;
            stop_test();
        end
    end
    function automatic logic [7:0] mem_b(input logic [14:0] a);
        return a[7:0] ^ 8'hc3;
    endfunction
    task automatic stop_test();
        if (fail_count == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk_val(input logic [14:0] got, input logic [14:0] exp, input string m);
        comparisons++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic chk_ack(input logic got, input logic exp);
        chk_val({14'h0, got}, {14'h0, exp}, "ack or flag");
    endtask
    task automatic wr(input logic [7:0] b, input logic exp);
        i_bus_master_model.wr_byte(b, ack);
        chk_ack(ack, exp);
    endtask
    task automatic rd(input logic a, input logic [7:0] exp);
        i_bus_master_model.rd_byte(a, d);
        chk_val({7'h0, d}, {7'h0, exp}, "read byte");
    endtask
    task automatic cmd(input logic [3:0] code, input logic [15:0] a);
        i_bus_master_model.start_c();
        wr({code, sel, 1'b0}, 1'b1);
        wr(a[15:8], 1'b1);
        wr(a[7:0], 1'b1);
    endtask
    task automatic rd_start(input logic [3:0] code);
        i_bus_master_model.start_c();
        wr({code, sel, 1'b1}, 1'b1);
    endtask
    task automatic poll(input logic exp);
        i_bus_master_model.start_c();
        wr({CODE_OTP, sel, 1'b0}, exp);
        i_bus_master_model.stop_c();
    endtask
    task automatic settle();
        repeat (10) @(posedge clk);
        #1;
    endtask
    task automatic set_wp(input logic v);
        @(posedge clk);
        #1 wp = v;
    endtask
    initial
    begin
        repeat (3) @(posedge clk);
        #1 chk_val({busy, locked, oe_n, 12'h0}, 15'h1000, "reset flags");
        chk_val(rd_addr, 15'h0000, "reset pointer");
        @(posedge clk);
        #1 resetn = 1'b1;
        repeat (8) @(posedge clk);
        #1;
        foreach (ROWS[i])
        begin
            i_bus_master_model.start_c();
            wr(ROWS[i].ctrl, ROWS[i].ack);
            if (ROWS[i].ctrl[0] && ROWS[i].ack)
                i_bus_master_model.rd_byte(1'b0, d);
            i_bus_master_model.stop_c();
        end
        // Blocked write: pointer moves, no cycle, no lock
        set_wp(1'b1);
        cmd(CODE_OTP, 16'h003e);
        repeat (3) wr(8'h11, 1'b1);
        i_bus_master_model.stop_c();
        settle();
        chk_ack(busy, 1'b0);
        chk_ack(locked, 1'b0);
        chk_val(rd_addr, 15'h0001, "blocked pointer");
        poll(1'b1);
        // Overrun write from a high address
        set_wp(1'b0);
        cmd(CODE_OTP, 16'h00be);
        for (int k = 0; k < 66; k++)
            wr(8'h40 + k[7:0], 1'b1);
        busy_cnt = 0;
        i_bus_master_model.stop_c();
        set_wp(1'b1);
        settle();
        chk_ack(busy, 1'b1);
        chk_ack(locked, 1'b1);
        poll(1'b0);
        for (int i = 0; i < 2000 && busy !== 1'b0; i++)
            @(posedge clk);
        #1;
        chk_ack(busy_cnt >= 64 * WR_CYC - 2 && busy_cnt <= 64 * WR_CYC + 2, 1'b1);
        poll(1'b1);
        set_wp(1'b0);
        cmd(CODE_OTP, 16'h003e);
        rd_start(CODE_OTP);
        rd(1'b1, 8'h80);
        rd(1'b1, 8'h81);
        rd(1'b0, FACTORY_FILL);
        i_bus_master_model.stop_c();
        settle();
        chk_val(rd_addr, 15'h0041, "sequential pointer");
        cmd(CODE_OTP, 16'h0000);
        rd_start(CODE_OTP);
        rd(1'b0, 8'h42);
        i_bus_master_model.stop_c();
        // Locked area takes no second write
        cmd(CODE_OTP, 16'h0001);
        wr(8'hee, 1'b1);
        i_bus_master_model.stop_c();
        settle();
        chk_ack(busy, 1'b0);
        // Array read over the top address, then the shared pointer
        cmd(CODE_ARRAY, 16'h0fff);
        rd_start(CODE_ARRAY);
        rd(1'b1, mem_b(MEM_LAST));
        rd(1'b0, mem_b(15'h0000));
        i_bus_master_model.stop_c();
        settle();
        chk_val(rd_addr, 15'h0001, "rollover pointer");
        chk_ack(oe_n, 1'b1);
        rd_start(CODE_OTP);
        rd(1'b0, 8'h43);
        i_bus_master_model.stop_c();
        // Array write only moves the pointer within its 32-byte page
        cmd(CODE_ARRAY, 16'h001f);
        repeat (2) wr(8'h55, 1'b1);
        i_bus_master_model.stop_c();
        settle();
        chk_val(rd_addr, 15'h0001, "array page pointer");
        // Mid-run reset clears the pointer and the volatile lock
        resetn = 1'b0;
        repeat (4) @(posedge clk);
        #1 chk_val({busy, locked, oe_n, 12'h0}, 15'h1000, "mid reset flags");
        chk_val(rd_addr, 15'h0000, "mid reset pointer");
        resetn = 1'b1;
        repeat (8) @(posedge clk);
        #1;
        rd_start(CODE_ARRAY);
        rd(1'b0, mem_b(15'h0000));
        i_bus_master_model.stop_c();
        stop_test();
    end
endmodule
